// >>> core/fcpq_pkg.sv
package fcpq_pkg;
   localparam int          FCPQ_NCNT       = 4;
   localparam int          FCPQ_NIN        = 4;
   localparam int          FCPQ_NOUT       = 2;
   // microsecond timebase
   localparam int          FCPQ_CLK_NS     = 8;
   localparam int          FCPQ_US_NS      = 1000;
   localparam int          FCPQ_US_CYC     = FCPQ_US_NS / FCPQ_CLK_NS;
   // per-counter window: counter index in addr[6:5], word in addr[4:2]
   localparam logic [2:0]  FCPQ_W_ACC      = 3'h0;
   localparam logic [2:0]  FCPQ_W_LATCH    = 3'h1;
   localparam logic [2:0]  FCPQ_W_PRELOAD  = 3'h2;
   localparam logic [2:0]  FCPQ_W_MATCH_A  = 3'h3;
   localparam logic [2:0]  FCPQ_W_MATCH_B  = 3'h4;
   localparam logic [2:0]  FCPQ_W_CFG      = 3'h5;
   localparam logic [2:0]  FCPQ_W_CTRL     = 3'h6;
   localparam logic [2:0]  FCPQ_W_STAT     = 3'h7;
   // global words at addr[7] set
   localparam logic [2:0]  FCPQ_W_IRQ_STAT = 3'h0;
   localparam logic [2:0]  FCPQ_W_IRQ_MASK = 3'h1;
   localparam logic [2:0]  FCPQ_W_OUT_SEL  = 3'h2;
   // cfg fields
   localparam int          FCPQ_CFG_MODE   = 0;
   localparam int          FCPQ_CFG_SEL1   = 2;
   localparam int          FCPQ_CFG_SEL2   = 4;
   localparam int          FCPQ_CFG_MSRC   = 6;
   localparam int          FCPQ_CFG_ACT_A  = 9;
   localparam int          FCPQ_CFG_ACT_B  = 11;
   localparam int          FCPQ_CFG_MK_EN  = 13;
   localparam int          FCPQ_CFG_W      = 17;
   localparam logic [2:0]  FCPQ_MSRC_SW    = 3'h4;
   // ctrl fields
   localparam int          FCPQ_CT_LATCH   = 0;
   localparam int          FCPQ_CT_PRELOAD = 1;
   localparam int          FCPQ_CT_CLEAR   = 2;
   localparam int          FCPQ_CT_DISABLE = 3;
   localparam int          FCPQ_CT_DIR     = 4;
   localparam int          FCPQ_CT_RESET   = 5;
   localparam int          FCPQ_CT_PRE_DIS = 6;
   localparam int          FCPQ_CT_LAT_DIS = 7;
   localparam int          FCPQ_CT_MK_LVL  = 8;
   localparam int          FCPQ_CT_MK_SW   = 12;
   localparam int          FCPQ_CT_W       = 13;
   // marker function slots
   localparam int          FCPQ_F_DIS      = 0;
   localparam int          FCPQ_F_LAT      = 1;
   localparam int          FCPQ_F_PRE      = 2;
   localparam int          FCPQ_F_CLR      = 3;
   // irq bits per counter: overflow, underflow, match
   localparam int          FCPQ_IRQ_PER    = 3;
   localparam logic [31:0] FCPQ_RST_WORD   = 32'h0;
   typedef enum logic [1:0] {
      FCPQ_PER_RISE, FCPQ_PER_FALL, FCPQ_QUAD_UP, FCPQ_QUAD_DN
   } fcpq_mode_t;
   typedef enum logic [1:0] {
      FCPQ_ACT_NONE, FCPQ_ACT_ON, FCPQ_ACT_OFF, FCPQ_ACT_TOGGLE
   } fcpq_act_t;
endpackage

// >>> core/fcpq_counter.sv
// What this block does
// R1: rising-edge period mode times each period in 1 us units from rising edge.
// R2: falling-edge period mode times each period in 1 us units from falling edge.
// R3: period mode accumulator always holds the latest completed period.
// R4: period mode honours only disable and latch; no preload, clear or marker.
// R5: quadrature uses two inputs, each channel selectable from any of four.
// R6: two quadrature variants choose count direction when channel 1 leads.
// R7: up on 1 rise/2 low, 2 rise/1 high, 1 fall/2 high, 2 fall/1 low.
// R8: quadrature gives four counts per full input cycle.
// R9: marker source is any of the four inputs or a software bit.
// R10: quadrature supports disable, latch, preload, clear and marker functions.
// R11: accumulator equal to either match value turns output on, off or toggles it.
// R12: each counter exposes a readable accumulator and a separate latched value.
// R13: software raises the reset bit to clear overflow, underflow and match state.
// R14: preload-disable blocks preload events; latch-disable blocks latch events.
// R15: counters 1 and 2 set marker active level per disable, latch, preload, clear.
// R16: a preload event loads the preload value into the accumulator.
// R17: an active disable stops the counter advancing.
// R18: a latch event copies the accumulator into the latched value and holds it.
// R19: wrap above maximum or below minimum sets a sticky overflow or underflow flag.
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module fcpq_counter
   import fcpq_pkg::*;
#(
   parameter int NCNT = FCPQ_NCNT
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [31:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic [FCPQ_NIN-1:0]  fast_in,
   output logic      [FCPQ_NOUT-1:0] match_out,
   output logic                      irq
);
   localparam int IRQW = NCNT * FCPQ_IRQ_PER;

   logic [7:0]           a;
   logic [1:0]           idx;
   logic [2:0]           word;
   logic                 addr_ok;
   logic                 wr_en;
   logic [FCPQ_NIN-1:0]  in_prev_q;
   logic [6:0]           us_cnt_q;
   logic                 us_tick;
   logic [31:0]          rd_cnt [NCNT];
   logic [NCNT-1:0]      hq;
   logic [IRQW-1:0]      ev;
   logic [IRQW-1:0]      irq_stat_q;
   logic [IRQW-1:0]      irq_mask_q;
   logic [3:0]           out_sel_q;
   logic [FCPQ_NOUT-1:0] match_out_q;
   logic [31:0]          prdata_q;
   logic [31:0]          rd_d;

   assign a       = paddr[7:0];
   assign idx     = a[6:5];
   assign word    = a[4:2];
   assign addr_ok = (paddr[31:8] == 24'h0) && (a[1:0] == 2'h0)
                    && (!a[7] || (a[6:5] == 2'h0 && word <= FCPQ_W_OUT_SEL));
   assign wr_en   = psel && penable && pwrite && addr_ok;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_ok;
   assign prdata  = prdata_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_prev_q <= 4'h0;
      end else begin
         in_prev_q <= fast_in;
      end
   end

   // one pulse per microsecond
   assign us_tick = (us_cnt_q == 7'(FCPQ_US_CYC - 1));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         us_cnt_q <= 7'h0;
      end else if (us_tick) begin
         us_cnt_q <= 7'h0;
      end else begin
         us_cnt_q <= us_cnt_q + 7'h1;
      end
   end

   for (genvar g = 0; g < NCNT; g++) begin : g_cnt
      logic [31:0]          acc_q, lat_q, pre_q, ma_q, mb_q, per_q, acc_d;
      logic [FCPQ_CFG_W-1:0] cfg_q;
      logic [FCPQ_CT_W-1:0] ctrl_q;
      logic                 ovf_q, unf_q, hq_q, eqa_q, eqb_q, started_q;
      logic                 ovf_set, unf_set, quad, c1, c1p, c2, c2p, up, dn;
      logic                 start_edge, marker, dis, lat_ev, pre_ev, clr_ev;
      logic                 hit_a, hit_b, hq_d;
      logic [3:0]           mk_lvl, mk_hit, trig, trig_q;
      logic [2:0]           msrc;
      fcpq_mode_t           mode;
      fcpq_act_t            act_a, act_b;

      function automatic logic wr_hit(input logic [2:0] w);
         return wr_en && !a[7] && idx == 2'(g) && word == w;
      endfunction

      assign mode  = fcpq_mode_t'(cfg_q[FCPQ_CFG_MODE +: 2]);
      assign act_a = fcpq_act_t'(cfg_q[FCPQ_CFG_ACT_A +: 2]);
      assign act_b = fcpq_act_t'(cfg_q[FCPQ_CFG_ACT_B +: 2]);
      assign quad  = (mode == FCPQ_QUAD_UP) || (mode == FCPQ_QUAD_DN);
      assign c1    = fast_in[cfg_q[FCPQ_CFG_SEL1 +: 2]];  // R5
      assign c1p   = in_prev_q[cfg_q[FCPQ_CFG_SEL1 +: 2]];
      assign c2    = fast_in[cfg_q[FCPQ_CFG_SEL2 +: 2]];  // R5
      assign c2p   = in_prev_q[cfg_q[FCPQ_CFG_SEL2 +: 2]];
      assign msrc  = cfg_q[FCPQ_CFG_MSRC +: 3];
      assign marker = (msrc >= FCPQ_MSRC_SW) ? ctrl_q[FCPQ_CT_MK_SW]
                                             : fast_in[msrc[1:0]];  // R9
      // counters 3 and 4 have fixed active-high marker
      assign mk_lvl = (g < 2) ? ctrl_q[FCPQ_CT_MK_LVL +: 4] : 4'hF;  // R15
      for (genvar f = 0; f < 4; f++) begin : g_fn
         // marker only acts in quadrature
         assign mk_hit[f] = quad && cfg_q[FCPQ_CFG_MK_EN + f]
                            && (marker == mk_lvl[f]);  // R10 R4
      end
      assign trig = {ctrl_q[FCPQ_CT_CLEAR], ctrl_q[FCPQ_CT_PRELOAD],
                     ctrl_q[FCPQ_CT_LATCH], 1'b0} | mk_hit;
      assign dis    = ctrl_q[FCPQ_CT_DISABLE] | mk_hit[FCPQ_F_DIS];  // R17
      assign lat_ev = trig[FCPQ_F_LAT] && !trig_q[FCPQ_F_LAT]
                      && !ctrl_q[FCPQ_CT_LAT_DIS];  // R14
      assign pre_ev = quad && trig[FCPQ_F_PRE] && !trig_q[FCPQ_F_PRE]
                      && !ctrl_q[FCPQ_CT_PRE_DIS];  // R14 R4
      assign clr_ev = quad && trig[FCPQ_F_CLR] && !trig_q[FCPQ_F_CLR];  // R4

      // each edge of either channel is one count
      always_comb begin
         up = (c1 && !c1p && !c2) || (c2 && !c2p && c1)
              || (!c1 && c1p && c2) || (!c2 && c2p && !c1);  // R7 R8
         dn = (c1 && !c1p && c2) || (c2 && !c2p && !c1)
              || (!c1 && c1p && !c2) || (!c2 && c2p && c1);  // R7
         if (mode == FCPQ_QUAD_DN) begin
            {up, dn} = {dn, up};  // R6
         end
      end

      assign start_edge = (mode == FCPQ_PER_FALL) ? (!c1 && c1p)  // R2
                                                  : (c1 && !c1p);  // R1

      always_comb begin
         acc_d   = acc_q;
         ovf_set = 1'b0;
         unf_set = 1'b0;
         if (quad) begin
            if (clr_ev) begin
               acc_d = FCPQ_RST_WORD;  // R10
            end else if (pre_ev) begin
               acc_d = pre_q;  // R16
            end else if (!dis && up && !dn) begin
               acc_d   = acc_q + 32'h1;
               ovf_set = &acc_q;  // R19
            end else if (!dis && dn && !up) begin
               acc_d   = acc_q - 32'h1;
               unf_set = (acc_q == 32'h0);  // R19
            end
         end else if (!dis) begin
            if (start_edge && started_q) begin
               acc_d = per_q;  // R3
            end
            ovf_set = us_tick && (&per_q) && !start_edge;  // R19
         end
      end

      // period timer saturates rather than wrapping
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            per_q     <= 32'h0;
            started_q <= 1'b0;
         end else if (quad || dis) begin
            per_q     <= 32'h0;
            started_q <= 1'b0;
         end else if (start_edge) begin
            per_q     <= 32'h0;  // R1 R2
            started_q <= 1'b1;
         end else if (us_tick && !(&per_q)) begin
            per_q <= per_q + 32'h1;  // R1 R2
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            acc_q  <= FCPQ_RST_WORD;
            trig_q <= 4'h0;
         end else begin
            acc_q  <= acc_d;
            trig_q <= trig;
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            lat_q <= FCPQ_RST_WORD;
         end else if (lat_ev) begin
            lat_q <= acc_q;  // R18
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pre_q  <= FCPQ_RST_WORD;
            ma_q   <= FCPQ_RST_WORD;
            mb_q   <= FCPQ_RST_WORD;
            cfg_q  <= '0;
            ctrl_q <= '0;
         end else begin
            if (wr_hit(FCPQ_W_PRELOAD)) pre_q <= pwdata;
            if (wr_hit(FCPQ_W_MATCH_A)) ma_q <= pwdata;
            if (wr_hit(FCPQ_W_MATCH_B)) mb_q <= pwdata;
            if (wr_hit(FCPQ_W_CFG))     cfg_q <= pwdata[FCPQ_CFG_W-1:0];
            if (wr_hit(FCPQ_W_CTRL))    ctrl_q <= pwdata[FCPQ_CT_W-1:0];
         end
      end

      // match acts once on reaching the value, not every cycle it holds
      assign hit_a = (acc_d == ma_q) && !eqa_q;  // R11
      assign hit_b = (acc_d == mb_q) && !eqb_q;  // R11
      always_comb begin
         hq_d = ctrl_q[FCPQ_CT_RESET] ? 1'b0 : hq_q;  // R13
         if (hit_a) begin
            unique case (act_a)
               FCPQ_ACT_NONE:   hq_d = hq_d;
               FCPQ_ACT_ON:     hq_d = 1'b1;
               FCPQ_ACT_OFF:    hq_d = 1'b0;
               FCPQ_ACT_TOGGLE: hq_d = !hq_d;
            endcase
         end
         if (hit_b) begin
            unique case (act_b)
               FCPQ_ACT_NONE:   hq_d = hq_d;
               FCPQ_ACT_ON:     hq_d = 1'b1;
               FCPQ_ACT_OFF:    hq_d = 1'b0;
               FCPQ_ACT_TOGGLE: hq_d = !hq_d;
            endcase
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            // accumulator and match values both start at zero, so no false hit
            eqa_q <= 1'b1;
            eqb_q <= 1'b1;
            hq_q  <= 1'b0;
         end else begin
            eqa_q <= (acc_d == ma_q);
            eqb_q <= (acc_d == mb_q);
            hq_q  <= hq_d;
         end
      end

      // a new wrap in the reset cycle still lands
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            ovf_q <= 1'b0;
            unf_q <= 1'b0;
         end else begin
            ovf_q <= ovf_set || (ovf_q && !ctrl_q[FCPQ_CT_RESET]);  // R19 R13
            unf_q <= unf_set || (unf_q && !ctrl_q[FCPQ_CT_RESET]);  // R19 R13
         end
      end

      assign hq[g] = hq_q;
      assign ev[g*FCPQ_IRQ_PER +: FCPQ_IRQ_PER] = {hit_a || hit_b, unf_set, ovf_set};

      always_comb begin
         unique case (word)
            FCPQ_W_ACC:     rd_cnt[g] = acc_q;  // R12
            FCPQ_W_LATCH:   rd_cnt[g] = lat_q;  // R12
            FCPQ_W_PRELOAD: rd_cnt[g] = pre_q;
            FCPQ_W_MATCH_A: rd_cnt[g] = ma_q;
            FCPQ_W_MATCH_B: rd_cnt[g] = mb_q;
            FCPQ_W_CFG:     rd_cnt[g] = {{(32-FCPQ_CFG_W){1'b0}}, cfg_q};
            FCPQ_W_CTRL:    rd_cnt[g] = {{(32-FCPQ_CT_W){1'b0}}, ctrl_q};
            FCPQ_W_STAT:    rd_cnt[g] = {29'h0, hq_q, unf_q, ovf_q};
         endcase
      end
   end

   // sticky status, write one to clear, a new event wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_q <= '0;
         irq_mask_q <= '0;
         out_sel_q  <= 4'h0;
      end else begin
         if (wr_en && a[7] && word == FCPQ_W_IRQ_STAT) begin
            irq_stat_q <= ev | (irq_stat_q & ~pwdata[IRQW-1:0]);
         end else begin
            irq_stat_q <= ev | irq_stat_q;
         end
         if (wr_en && a[7] && word == FCPQ_W_IRQ_MASK) irq_mask_q <= pwdata[IRQW-1:0];
         if (wr_en && a[7] && word == FCPQ_W_OUT_SEL)  out_sel_q <= pwdata[3:0];
      end
   end
   assign irq = |(irq_stat_q & irq_mask_q);

   for (genvar k = 0; k < FCPQ_NOUT; k++) begin : g_out
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            match_out_q[k] <= 1'b0;
         end else begin
            match_out_q[k] <= hq[out_sel_q[2*k +: 2]];  // R11
         end
      end
   end
   assign match_out = match_out_q;

   always_comb begin
      rd_d = 32'h0;
      if (!a[7]) begin
         rd_d = rd_cnt[idx];
      end else begin
         unique case (word)
            FCPQ_W_IRQ_STAT: rd_d = {{(32-IRQW){1'b0}}, irq_stat_q};
            FCPQ_W_IRQ_MASK: rd_d = {{(32-IRQW){1'b0}}, irq_mask_q};
            FCPQ_W_OUT_SEL:  rd_d = {28'h0, out_sel_q};
            default:         rd_d = 32'h0;
         endcase
      end
   end

   // read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         prdata_q <= addr_ok ? rd_d : 32'h0;
      end
   end
endmodule
`default_nettype wire

// >>> test/fcpq_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module fcpq_monitor
   import fcpq_pkg::*;
(
   input wire logic                 pclk,
   input wire logic                 presetn,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [31:0]          paddr,
   input wire logic [31:0]          pwdata,
   input wire logic [31:0]          prdata,
   input wire logic                 pready,
   input wire logic                 pslverr,
   input wire logic [FCPQ_NIN-1:0]  fast_in,
   input wire logic [FCPQ_NOUT-1:0] match_out,
   input wire logic                 irq
);
   logic [FCPQ_NIN-1:0] fin_q;
   logic [3:0]          quiet_q;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // cycles since the last input edge or register write, saturating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fin_q <= '0;
         quiet_q <= 4'hF;
      end else begin
         fin_q <= fast_in;
         if (fast_in != fin_q || (psel && penable && pwrite))
            quiet_q <= 4'h0;
         else if (quiet_q != 4'hF)
            quiet_q <= quiet_q + 4'h1;
      end
   end

   property p_ready_in_access;
      psel && penable |-> pready;
   endproperty
   a_ready_in_access: assert property (p_ready_in_access) else $error("no ready");
   property p_err_in_access;
      pslverr |-> psel && penable;
   endproperty
   a_err_in_access: assert property (p_err_in_access) else $error("stray slverr");
   property p_err_read_zero;
      psel && penable && !pwrite && pslverr |-> prdata == 32'h0;
   endproperty
   a_err_read_zero: assert property (p_err_read_zero) else $error("bad read data");
   property p_rdata_hold;
      !(psel && !penable && !pwrite) |=> $stable(prdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   property p_match_cause;
      $changed(match_out) |-> quiet_q < 4'h6;
   endproperty
   a_match_cause: assert property (p_match_cause) else $error("match out uncaused");
   property p_irq_rise_cause;
      $rose(irq) |-> quiet_q < 4'h6;
   endproperty
   a_irq_rise_cause: assert property (p_irq_rise_cause) else $error("irq uncaused");
   property p_irq_fall_cause;
      $fell(irq) |-> $past(psel && penable && pwrite);
   endproperty
   a_irq_fall_cause: assert property (p_irq_fall_cause) else $error("irq fell alone");
   property p_reset_idle;
      $rose(presetn) |-> match_out == 2'h0 && irq == 1'b0 && prdata == 32'h0;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
endmodule
`default_nettype wire

// >>> test/fcpq_encoder_model.sv
`timescale 1ns/100ps
`default_nettype none
module fcpq_encoder_model (
   input  wire logic       clk,
   output var  logic [3:0] fast_in
);
   initial fast_in = 4'h0;

   // channel 1 on bit 0, channel 2 on bit 1, one edge every 4 clocks
   task automatic quad(input int cyc, input logic fwd);
      @(posedge clk);
      for (int i = 0; i < 4 * cyc; i++) begin
         if ((fast_in[0] == fast_in[1]) == fwd)
            fast_in[0] <= ~fast_in[0];
         else
            fast_in[1] <= ~fast_in[1];
         repeat (4) @(posedge clk);
      end
   endtask

   // pulse train on bit 3 for the period timer
   task automatic pulses(input int n, input int hi, input int lo);
      @(posedge clk);
      repeat (n) begin
         fast_in[3] <= 1'b1;
         repeat (hi) @(posedge clk);
         fast_in[3] <= 1'b0;
         repeat (lo) @(posedge clk);
      end
   endtask
endmodule
`default_nettype wire

// >>> test/fcpq_counter_tb.sv
`timescale 1ns/100ps
`default_nettype none
module fcpq_counter_tb
   import fcpq_pkg::*;
;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [3:0]  fast_in;
   logic [1:0]  match_out;
   logic        irq;
   logic        err_q;
   logic [31:0] rv;
   int          n_mismatch = 0;
   int          compares = 0;

   always #4 pclk = ~pclk;

   fcpq_counter fcpq_counter_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .fast_in(fast_in), .match_out(match_out), .irq(irq)
   );
   fcpq_encoder_model fcpq_encoder_model_i (.clk(pclk), .fast_in(fast_in));

   function automatic logic [31:0] ra(input int n, input logic [2:0] w);
      return {25'h0, 2'(n), w, 2'h0};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // pready is tied high in the counter, so this wait ends at once
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rv = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdc(input logic [31:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rv, e);
   endtask

   task automatic final_report;
      $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      final_report();
   end

   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(ra(0, FCPQ_W_ACC), 32'h0);
      rdc(32'h8C, 32'h0);
      chk({31'h0, err_q}, 32'h1);
      wr(ra(0, FCPQ_W_PRELOAD), 32'hA5A50001);
      rdc(ra(0, FCPQ_W_PRELOAD), 32'hA5A50001);
      wr(ra(0, FCPQ_W_ACC), 32'h55);
      rdc(ra(0, FCPQ_W_ACC), 32'h0);
      // counter 0 quad up with match A on, 1 quad down, 2 quad up swapped
      wr(ra(0, FCPQ_W_CFG), 32'h212);
      wr(ra(1, FCPQ_W_CFG), 32'h13);
      wr(ra(2, FCPQ_W_CFG), 32'h06);
      wr(ra(0, FCPQ_W_MATCH_A), 32'h4);
      wr(32'h84, 32'h4);
      chk({31'h0, irq}, 32'h0);
      fcpq_encoder_model_i.quad(1, 1'b1);
      rdc(ra(0, FCPQ_W_ACC), 32'h4);
      rdc(ra(1, FCPQ_W_ACC), 32'hFFFFFFFC);
      rdc(ra(2, FCPQ_W_ACC), 32'hFFFFFFFC);
      apb(1'b0, ra(1, FCPQ_W_STAT), 32'h0);
      chk(rv & 32'h2, 32'h2);
      chk({30'h0, match_out}, 32'h3);
      chk({31'h0, irq}, 32'h1);
      wr(32'h80, 32'h4);
      chk({31'h0, irq}, 32'h0);
      wr(ra(0, FCPQ_W_CTRL), 32'h20);
      wr(ra(0, FCPQ_W_CTRL), 32'h0);
      chk({30'h0, match_out}, 32'h0);
      fcpq_encoder_model_i.quad(2, 1'b1);
      fcpq_encoder_model_i.quad(1, 1'b0);
      rdc(ra(0, FCPQ_W_ACC), 32'h8);
      wr(ra(0, FCPQ_W_CTRL), 32'h1);
      wr(ra(0, FCPQ_W_CTRL), 32'h0);
      rdc(ra(0, FCPQ_W_LATCH), 32'h8);
      wr(ra(0, FCPQ_W_CTRL), 32'h80);
      wr(ra(0, FCPQ_W_CTRL), 32'h81);
      fcpq_encoder_model_i.quad(1, 1'b1);
      rdc(ra(0, FCPQ_W_LATCH), 32'h8);
      wr(ra(0, FCPQ_W_PRELOAD), 32'h100);
      wr(ra(0, FCPQ_W_CTRL), 32'h40);
      wr(ra(0, FCPQ_W_CTRL), 32'h42);
      rdc(ra(0, FCPQ_W_ACC), 32'hC);
      wr(ra(0, FCPQ_W_CTRL), 32'h0);
      wr(ra(0, FCPQ_W_CTRL), 32'h2);
      rdc(ra(0, FCPQ_W_ACC), 32'h100);
      wr(ra(0, FCPQ_W_CTRL), 32'h8);
      fcpq_encoder_model_i.quad(1, 1'b1);
      rdc(ra(0, FCPQ_W_ACC), 32'h100);
      wr(ra(0, FCPQ_W_CTRL), 32'h4);
      rdc(ra(0, FCPQ_W_ACC), 32'h0);
      // marker clear from input 3 at level high, then from the software bit at level low
      wr(ra(0, FCPQ_W_CTRL), 32'h800);
      wr(ra(0, FCPQ_W_CFG), 32'h102D2);
      fcpq_encoder_model_i.quad(1, 1'b1);
      wr(32'h88, 32'h4);
      fcpq_encoder_model_i.pulses(1, 4, 4);
      rdc(ra(0, FCPQ_W_ACC), 32'h0);
      chk({30'h0, match_out}, 32'h1);
      wr(ra(0, FCPQ_W_CTRL), 32'h1000);
      wr(ra(0, FCPQ_W_CFG), 32'h10312);
      fcpq_encoder_model_i.quad(1, 1'b1);
      wr(ra(0, FCPQ_W_CTRL), 32'h0);
      rdc(ra(0, FCPQ_W_ACC), 32'h0);
      // period timer on input 3: 625 clocks is 5 us, 1000 clocks is 8 us
      wr(ra(3, FCPQ_W_CFG), 32'h0C);
      fcpq_encoder_model_i.pulses(3, 200, 425);
      apb(1'b0, ra(3, FCPQ_W_ACC), 32'h0);
      chk(32'(rv >= 32'h4 && rv <= 32'h6), 32'h1);
      wr(ra(3, FCPQ_W_PRELOAD), 32'h77);
      wr(ra(3, FCPQ_W_CTRL), 32'h6);
      apb(1'b0, ra(3, FCPQ_W_ACC), 32'h0);
      chk(32'(rv >= 32'h4 && rv <= 32'h6), 32'h1);
      wr(ra(3, FCPQ_W_CFG), 32'h0D);
      fcpq_encoder_model_i.pulses(3, 300, 700);
      apb(1'b0, ra(3, FCPQ_W_ACC), 32'h0);
      chk(32'(rv >= 32'h7 && rv <= 32'h9), 32'h1);
      final_report();
   end
endmodule

bind fcpq_counter fcpq_monitor fcpq_monitor_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .fast_in(fast_in), .match_out(match_out), .irq(irq)
);
`default_nettype wire
